/* logic/dacswc_pkg.sv */
`default_nettype none
package dacswc_pkg;
  // Word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int POS_SEL_HIGH = 15;
  localparam int POS_SPEED = 14;
  localparam int POS_POWER = 13;
  localparam int POS_SEL_LOW = 12;
  localparam int POS_REFSEL_HIGH = 1;
  localparam int POS_REFSEL_LOW = 0;
  // Register select codes
  localparam logic [1:0] SEL_DAC = 2'h0;
  localparam logic [1:0] SEL_CONFIG = 2'h3;
  // Reference select codes
  localparam logic [1:0] REF_EXT_A = 2'h0;
  localparam logic [1:0] REF_INT_1V024 = 2'h1;
  localparam logic [1:0] REF_INT_2V048 = 2'h2;
  localparam logic [1:0] REF_EXT_B = 2'h3;
  // Reset values
  localparam logic [11:0] RST_CODE = 12'h000;
  localparam logic [1:0] RST_REFSEL = 2'h0;
  localparam logic RST_SPEED = 1'b0;
  localparam logic RST_POWER = 1'b0;

  typedef enum logic [1:0] {
    DACSWC_REF_EXTERNAL,
    DACSWC_REF_1V024,
    DACSWC_REF_2V048
  } dacswc_ref_e;

  // Settings presented to the analog core
  typedef struct packed {
    logic [11:0] code;
    logic speed_select;
    logic power_down_bit;
    logic [1:0] refsel;
    dacswc_ref_e ref_source;
  } dacswc_out_s;
endpackage : dacswc_pkg
`default_nettype wire

/* logic/dacswc_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Config writes keep only payload bits 1:0 as reference select.
// - Reference select 00/11 external, 01 internal 1.024 V, 10 internal 2.048 V.
// - Output updates on the rising serial clock edge after bit 16, or when frame sync rises.
// - Reference configuration persists across later code writes.
// - Chip select low, frame sync fall starts word; MSB first on falling edges.
// - Word transfers to its latch after 16 bits or when frame sync rises.
// - Bit 14 sets speed, bit 13 power down, bits 15 and 12 select target.
// - Target 00 goes to code, 11 to config; 01 and 10 reserved.
module dacswc_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic frame_sync,
  input wire logic cs_n,
  output logic [11:0] dac_code,
  output logic speed_select,
  output logic power_down_bit,
  output logic [1:0] refsel,
  output dacswc_pkg::dacswc_ref_e ref_source,
  output logic update_pulse
);
  // All state of the block in one register
  typedef struct packed {
    // Two-stage synchronisers for the pins
    logic [1:0] sclk_sy;
    logic [1:0] din_sy;
    logic [1:0] fs_sy;
    logic [1:0] cs_sy;
    // Edge detector history
    logic sclk_prev;
    logic fs_prev;
    // Word assembly
    logic active;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic pend;
    logic [15:0] word;
    // Settings driven to the analog core
    dacswc_pkg::dacswc_out_s out;
    logic upd;
    logic cut; // Word ended early by frame sync
  } dacswc_state_s;

  // Registered state and its next value
  dacswc_state_s st_q;
  dacswc_state_s st_d;
  // Pins after the second synchroniser stage
  logic sclk_s;
  logic din_s;
  logic fs_s;
  logic cs_s;
  // One-cycle edge strobes of the synchronised pins
  logic sclk_fall;
  logic sclk_rise;
  logic fs_fall;
  logic fs_rise;
  // Register select pair of the captured word
  logic [1:0] tgt;

  // Synchronised pins and edge detection on second stage only
  always_comb begin
    sclk_s = st_q.sclk_sy[1];
    din_s = st_q.din_sy[1];
    fs_s = st_q.fs_sy[1];
    cs_s = st_q.cs_sy[1];
    // Edges compare the second stage with its previous value
    sclk_fall = st_q.sclk_prev & ~sclk_s;
    sclk_rise = ~st_q.sclk_prev & sclk_s;
    fs_fall = st_q.fs_prev & ~fs_s;
    fs_rise = ~st_q.fs_prev & fs_s;
    // Target from bits 15 and 12
    tgt = {st_q.word[dacswc_pkg::POS_SEL_HIGH], st_q.word[dacswc_pkg::POS_SEL_LOW]};
  end

  // Next state: synchronisers, word shifter and latch transfer
  always_comb begin
    st_d = st_q;
    // Two flip-flop synchronisers, the second stage feeds all logic
    st_d.sclk_sy = {st_q.sclk_sy[0], sclk};
    st_d.din_sy = {st_q.din_sy[0], din};
    st_d.fs_sy = {st_q.fs_sy[0], frame_sync};
    st_d.cs_sy = {st_q.cs_sy[0], cs_n};
    // Previous levels for edge detection
    st_d.sclk_prev = sclk_s;
    st_d.fs_prev = fs_s;
    // Update strobe lasts a single cycle
    st_d.upd = 1'h0;
    // Word start and shifting
    if (!cs_s && fs_fall) begin
      st_d.active = 1'h1;
      st_d.cnt = '0;
      st_d.shift = '0;
      st_d.cut = 1'h0;
    end else if (st_q.active && !cs_s && sclk_fall && !fs_s) begin
      st_d.shift = {st_q.shift[14:0], din_s};
      st_d.cnt = st_q.cnt + 5'h01;
      // Sixteenth bit closes the word, transfer waits for the next rise
      if (st_q.cnt == 5'(dacswc_pkg::WORD_BITS - 1)) begin
        st_d.active = 1'h0;
        st_d.pend = 1'h1;
        st_d.word = {st_q.shift[14:0], din_s};
      end
    end else if (st_q.active && fs_rise) begin
      // Frame sync rose early, partial word stays right aligned
      st_d.active = 1'h0;
      st_d.pend = 1'h1;
      st_d.cut = 1'h1;
      st_d.word = st_q.shift;
    end
    // Full word waits for a serial clock or frame sync rise, a cut word applies at once
    if (st_q.pend && (sclk_rise || fs_rise || st_q.cut)) begin
      st_d.pend = 1'h0;
      st_d.cut = 1'h0;
      // Reserved targets are dropped without any update
      if (tgt == dacswc_pkg::SEL_DAC || tgt == dacswc_pkg::SEL_CONFIG) begin
        st_d.upd = 1'h1;
        st_d.out.speed_select = st_q.word[dacswc_pkg::POS_SPEED];
        st_d.out.power_down_bit = st_q.word[dacswc_pkg::POS_POWER];
        // Code writes leave the reference select untouched
        if (tgt == dacswc_pkg::SEL_DAC) begin
          st_d.out.code = st_q.word[11:0];
        end else begin
          st_d.out.refsel = {st_q.word[dacswc_pkg::POS_REFSEL_HIGH],
                             st_q.word[dacswc_pkg::POS_REFSEL_LOW]};
        end
      end
    end
    // Reference decode follows the next reference select
    unique case (st_d.out.refsel)
      dacswc_pkg::REF_INT_1V024: st_d.out.ref_source = dacswc_pkg::DACSWC_REF_1V024;
      dacswc_pkg::REF_INT_2V048: st_d.out.ref_source = dacswc_pkg::DACSWC_REF_2V048;
      dacswc_pkg::REF_EXT_A, dacswc_pkg::REF_EXT_B: begin
        st_d.out.ref_source = dacswc_pkg::DACSWC_REF_EXTERNAL;
      end
    endcase
  end

  // State register with synchronous reset, pins parked at idle levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
      st_q.sclk_sy <= 2'h3;
      st_q.fs_sy <= 2'h3;
      st_q.cs_sy <= 2'h3;
      st_q.sclk_prev <= 1'h1;
      st_q.fs_prev <= 1'h1;
      // Settings return to their power-on values
      st_q.out.code <= dacswc_pkg::RST_CODE;
      st_q.out.refsel <= dacswc_pkg::RST_REFSEL;
      st_q.out.speed_select <= dacswc_pkg::RST_SPEED;
      st_q.out.power_down_bit <= dacswc_pkg::RST_POWER;
      st_q.out.ref_source <= dacswc_pkg::DACSWC_REF_EXTERNAL;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign dac_code = st_q.out.code;
  assign speed_select = st_q.out.speed_select;
  assign power_down_bit = st_q.out.power_down_bit;
  assign refsel = st_q.out.refsel;
  assign ref_source = st_q.out.ref_source;
  assign update_pulse = st_q.upd;

  // Reference decode
  AST_REF_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
    (refsel == 2'h1) |-> (ref_source == dacswc_pkg::DACSWC_REF_1V024))
    else $error("reference decode wrong");
  AST_REF_2V048: assert property (@(posedge clk_sys) disable iff (rst)
    (refsel == 2'h2) |-> (ref_source == dacswc_pkg::DACSWC_REF_2V048))
    else $error("upper internal reference decode wrong");
  AST_EXT_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
    (refsel == 2'h0 || refsel == 2'h3) |-> (ref_source == dacswc_pkg::DACSWC_REF_EXTERNAL))
    else $error("external decode wrong");
  // Code and reference select change only on an applied word of their own target
  AST_CODE_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
    !update_pulse |-> ##1 (update_pulse || $stable(dac_code)))
    else $error("code changed without update");
  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.pend && tgt[1] != tgt[0]) |=> !update_pulse)
    else $error("reserved word applied");
  AST_REF_ON_CODE: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.pend && tgt == 2'h0) |=> $stable(refsel))
    else $error("code write altered reference");
  AST_CODE_ON_CFG: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.pend && tgt == 2'h3) |=> $stable(dac_code))
    else $error("config write altered code");
  // Reset clears the settings
  AST_RESET_CLEAR: assert property (@(posedge clk_sys) rst |=>
    (dac_code == dacswc_pkg::RST_CODE && refsel == dacswc_pkg::RST_REFSEL &&
     speed_select == dacswc_pkg::RST_SPEED && power_down_bit == dacswc_pkg::RST_POWER))
    else $error("reset left settings behind");
  // Control bits of every applied word
  AST_SPEED: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(update_pulse) |-> (speed_select == $past(st_q.word[14])))
    else $error("speed bit not applied");
  AST_POWER: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(update_pulse) |-> (power_down_bit == $past(st_q.word[13])))
    else $error("power bit not applied");
  // Word framing and update timing
  AST_FULL_WORD: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.active && sclk_fall && !fs_s && !cs_s && st_q.cnt == 5'h0F) |=> st_q.pend)
    else $error("word not closed after sixteen bits");
  AST_SHORT_END: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.active && fs_rise) |=> (st_q.pend && st_q.cut))
    else $error("early frame end not closed");
  AST_WAIT_RISE: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.pend && !st_q.cut && !sclk_rise && !fs_rise) |=> !update_pulse)
    else $error("update before serial clock rise");
  AST_ONE_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    update_pulse |=> !update_pulse)
    else $error("update strobe longer than one cycle");
  AST_UNSELECTED: assert property (@(posedge clk_sys) disable iff (rst)
    (cs_s && !st_q.active) |=> !st_q.active)
    else $error("word started without chip select");
endmodule : dacswc_core
`default_nettype wire

/* testbench/dacswc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host serial port that frames words into the converter
module dacswc_host (
  input wire logic clk_sys,
  output logic sclk,
  output logic din,
  output logic frame_sync,
  output logic cs_n
);
  // Idle levels, serial clock parked high between frames
  initial begin
    sclk = 1'h1;
    din = 1'h0;
    frame_sync = 1'h1;
    cs_n = 1'h1;
  end
  // Send the low n bits of w, highest first, 400 ns per bit, chip select at sel_n
  task automatic send(input logic [15:0] w, input int n, input logic sel_n);
    cs_n = sel_n;
    repeat (4) @(negedge clk_sys);
    frame_sync = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      repeat (4) @(negedge clk_sys);
      sclk = 1'h0;
      repeat (4) @(negedge clk_sys);
      sclk = 1'h1;
    end
    // Released data line shows the inverse of the last bit
    din = ~din;
    repeat (4) @(negedge clk_sys);
    frame_sync = 1'h1;
    cs_n = 1'h1;
  endtask : send
endmodule : dacswc_host
`default_nettype wire

/* testbench/dacswc_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dacswc_tb_top;
  logic clk_sys;
  logic rst;
  logic sclk;
  logic din;
  logic frame_sync;
  logic cs_n;
  logic [11:0] dac_code;
  logic speed_select;
  logic power_down_bit;
  logic [1:0] refsel;
  dacswc_pkg::dacswc_ref_e ref_source;
  logic update_pulse;
  int n_errors = 0;
  int checks_done = 0;
  int n_upd = 0;
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Count applied words between clock edges
  always @(negedge clk_sys) if (update_pulse === 1'h1) n_upd++;
  dacswc_core u_dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .din(din),
    .frame_sync(frame_sync), .cs_n(cs_n), .dac_code(dac_code),
    .speed_select(speed_select), .power_down_bit(power_down_bit),
    .refsel(refsel), .ref_source(ref_source), .update_pulse(update_pulse));
  dacswc_host u_host (.clk_sys(clk_sys), .sclk(sclk), .din(din),
    .frame_sync(frame_sync), .cs_n(cs_n));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task results;
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // One word, then count the updates it caused
  task xfer(input logic [15:0] w, input int n, input int p, input logic sel_n);
    int base;
    base = n_upd;
    u_host.send(w, n, sel_n);
    repeat (6) @(negedge clk_sys);
    chk(16'(n_upd - base), 16'(p));
  endtask : xfer
  task t_reset;
    chk({dac_code, speed_select, power_down_bit, refsel}, 16'h0000);
    chk(16'(ref_source), 16'h0000);
  endtask : t_reset
  task t_config;
    xfer(16'hD002, 16, 1, 1'h0);
    chk(16'({speed_select, power_down_bit, refsel}), 16'h000A);
    chk(16'(ref_source), 16'h0002);
  endtask : t_config
  task t_persist;
    xfer(16'h4ABC, 16, 1, 1'h0);
    chk(16'({dac_code, refsel}), 16'h2AF2);
  endtask : t_persist
  task t_refs;
    logic [1:0] src [4];
    src = '{2'h0, 2'h1, 2'h2, 2'h0};
    for (int k = 0; k < 4; k++) begin
      xfer(16'hFFFC | 16'(k), 16, 1, 1'h0);
      chk(16'(refsel), 16'(k));
      chk(16'(ref_source), 16'(src[k]));
      chk(16'({power_down_bit, dac_code}), 16'h1ABC);
    end
  endtask : t_refs
  task t_reserved;
    xfer(16'h1FFF, 16, 0, 1'h0);
    xfer(16'h8000, 16, 0, 1'h0);
    chk(16'({dac_code, refsel, power_down_bit}), 16'h55E7);
  endtask : t_reserved
  task t_short;
    xfer(16'h00A5, 8, 1, 1'h0);
    chk({dac_code, speed_select, power_down_bit, refsel}, 16'h0A53);
  endtask : t_short
  // Frames with chip select high are ignored
  task t_unselected;
    xfer(16'h4123, 16, 0, 1'h1);
    chk(16'(dac_code), 16'h00A5);
    chk(16'(speed_select), 16'h0000);
  endtask : t_unselected
  // Reset in mid-run returns every setting to zero
  task t_rerun;
    rst = 1'h1;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    repeat (4) @(negedge clk_sys);
    t_reset();
  endtask : t_rerun
  // Main sequence
  initial begin
    rst = 1'h1;
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_config();
    t_persist();
    t_refs();
    t_reserved();
    t_short();
    t_unselected();
    t_rerun();
    results();
  end
  // Watchdog
  initial begin
    #500000;
    n_errors++;
    results();
  end
endmodule : dacswc_tb_top
`default_nettype wire
